// *** hw/ffe_pkg.sv ***
// package: constants and state types of the filter front end
package ffe_pkg;
  // configuration port addresses
  localparam logic [2:0] CFG_FILTER_ADDR = 3'h0;
  localparam logic [2:0] COEFF_PORT_ADDR = 3'h2;
  localparam logic [2:0] IN_FMT_ADDR = 3'h3;
  localparam logic [2:0] MIX_FMT_ADDR = 3'h7;
  // field positions
  localparam int RD_EN_BIT = 4;
  localparam int FMT_OFFSET_BIT = 5;
  localparam int IN_MSB_FIRST_BIT = 6;
  localparam int MIX_MSB_FIRST_BIT = 5;
  localparam int MIX_SERIAL_SEL_BIT = 6;
  // reset values
  localparam logic [7:0] CFG_FILTER_RST = 8'h00;
  localparam logic [7:0] IN_FMT_RST = 8'h18;
  localparam logic [7:0] MIX_FMT_RST = 8'h18;
  // sizes
  localparam int COEFF_WORDS = 128;
  localparam int COEFF_AW = 7;
  localparam int WORD_W = 24;
  localparam int PROD_W = 48;
  localparam logic [4:0] LEN_MIN = 5'h08;
  localparam logic [4:0] LEN_MAX = 5'h18;
  localparam logic [6:0] WPTR_LAST = 7'h7F;
  localparam logic [1:0] LANE_LAST = 2'h3;
  localparam logic [1:0] FIFO_DEPTH = 2'h2;
  // table mix factors
  localparam logic [23:0] MIX_ZERO = 24'h000000;
  localparam logic [23:0] MIX_PLUS_ONE = 24'h7FFFFF;
  localparam logic [23:0] MIX_MINUS_ONE = 24'h800000;

  typedef struct packed {
    logic wr_n_d;
    logic rd_n_d;
    logic sclk_d;
    logic cclk_d;
    logic [7:0] cfg_filter;
    logic [7:0] in_fmt;
    logic [7:0] mix_fmt;
    logic [31:0] hold;
    logic [1:0] lane;
    logic [6:0] wptr;
    logic wfull;
    logic [8:0] rptr;
    logic [7:0] rdata;
    logic [23:0] in_sr;
    logic [4:0] in_cnt;
    logic [23:0] in_hold;
    logic [23:0] mx_sr;
    logic [4:0] mx_cnt;
    logic [23:0] mx_hold;
    logic [23:0] tbl;
    logic [23:0] m_a;
    logic [23:0] m_b;
    logic [4:0] m_cnt;
    logic m_busy;
    logic [47:0] prod;
    logic prod_v;
    logic [47:0] f0;
    logic [47:0] f1;
    logic [1:0] f_cnt;
    logic [47:0] out_data;
    logic out_wr;
  } ffe_state_s;

  // pins that cross into the clk_in domain
  typedef struct packed {
    logic wr_n;
    logic rd_n;
    logic sclk;
    logic din;
    logic smp_sync;
    logic mix_din;
    logic mix_sync;
    logic cclk;
    logic [2:0] addr;
    logic [7:0] data;
  } ffe_pins_s;
endpackage

// *** hw/ffe_sync.sv ***
// two flip-flop synchroniser for a vector of pins
`timescale 1ns/10ps
module ffe_sync #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic sys_rst_in,
  // pins
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  logic [W-1:0] meta_r;
  logic [W-1:0] sync_r;

  // first stage feeds only the second
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      meta_r <= '1;
      sync_r <= '1;
    end else begin
      meta_r <= async_in;
      sync_r <= meta_r;
    end
  end

  assign sync_out = sync_r;
endmodule // ffe_sync

// *** hw/ffe_front_end.sv ***
// filter front end: coefficient store, serial inputs, mixer, product hand-off
// Behaviour
// - store 128 words of 32 bits, four bytes each
// - bytes arrive LSB first into ascending lanes
// - fourth byte commits word, pointer advances
// - pointer halts at last word, writes ignored
// - other register access resets coefficient pointers
// - loads accepted while filtering continues
// - read enable resets read pointer, blocks writes
// - read strobe fall gives next stored byte
// - sample bit shifted on serial clock rise
// - freeze after length, transfer on sync
// - format, bit order, zeroed low bits
// - serial mix factor loaded like samples
// - table mode loads table, decodes pins anew
// - table: 00/10 zero, 01 minus, 11 plus
// - sync starts multiply, product to register file
// - input format: length, number system, order
// - mix select bit: serial or table
`timescale 1ns/10ps
module ffe_front_end (
  // clock and reset
  input wire logic clk_in,
  input wire logic sys_rst_in,
  // configuration port
  input wire logic [2:0] config_address_lines_in,
  input wire logic [7:0] config_byte_bus_in,
  output logic [7:0] config_byte_bus_out,
  output logic config_byte_bus_oe_out,
  input wire logic wr_n_in,
  input wire logic rd_n_in,
  // serial inputs
  input wire logic serial_clock_in,
  input wire logic sample_serial_in,
  input wire logic sample_word_sync_in,
  input wire logic mix_serial_in,
  input wire logic mix_word_sync_in,
  // register file side
  input wire logic compute_clock_in,
  input wire logic regfile_ready_in,
  output logic [47:0] regfile_data_out,
  output logic regfile_wr_out
);
  ffe_pkg::ffe_state_s s_r;
  ffe_pkg::ffe_state_s s_nxt;
  ffe_pkg::ffe_pins_s pins_raw;
  ffe_pkg::ffe_pins_s p;
  logic [31:0] coeff_mem [ffe_pkg::COEFF_WORDS];
  logic mem_we;
  logic [6:0] mem_addr;
  logic [31:0] mem_wdata;
  logic [31:0] mem_rword;

  assign pins_raw = '{wr_n: wr_n_in, rd_n: rd_n_in, sclk: serial_clock_in,
                      din: sample_serial_in, smp_sync: sample_word_sync_in,
                      mix_din: mix_serial_in, mix_sync: mix_word_sync_in,
                      cclk: compute_clock_in, addr: config_address_lines_in,
                      data: config_byte_bus_in};

  ffe_sync #(.W($bits(ffe_pkg::ffe_pins_s))) u_sync (
    .clk_in(clk_in),
    .sys_rst_in(sys_rst_in),
    .async_in(pins_raw),
    .sync_out(p)
  );

  // out-of-range lengths are clamped so the shifter never stalls forever
  function automatic logic [4:0] eff_len(input logic [7:0] fmt);
    logic [4:0] l;
    l = fmt[4:0];
    if (l < ffe_pkg::LEN_MIN) l = ffe_pkg::LEN_MIN;
    if (l > ffe_pkg::LEN_MAX) l = ffe_pkg::LEN_MAX;
    return l;
  endfunction

  // left-justify a finished word, zero low bits, make it two's complement
  function automatic logic [23:0] align(input logic [23:0] sr, input logic [4:0] len,
                                        input logic msb_first, input logic offset);
    logic [23:0] v;
    logic [4:0] sh;
    sh = ffe_pkg::LEN_MAX - len;
    v = msb_first ? (sr << sh) : sr;
    if (offset) v[23] = ~v[23];
    return v;
  endfunction

  function automatic logic [23:0] shift_in(input logic [23:0] sr, input logic b,
                                           input logic msb_first);
    return msb_first ? {sr[22:0], b} : {b, sr[23:1]};
  endfunction

  function automatic logic [23:0] tbl_decode(input logic mix_sync, input logic mix_din);
    logic [23:0] v;
    unique case ({mix_sync, mix_din})
      2'b01: v = ffe_pkg::MIX_MINUS_ONE;
      2'b11: v = ffe_pkg::MIX_PLUS_ONE;
      default: v = ffe_pkg::MIX_ZERO;
    endcase
    return v;
  endfunction

  assign mem_rword = coeff_mem[s_r.rptr[8:2]];

  always_comb begin
    logic wr_rise;
    logic rd_fall;
    logic sclk_rise;
    logic cclk_rise;
    logic rd_en;
    logic [4:0] in_len;
    logic [4:0] mx_len;
    logic in_msb;
    logic mx_msb;
    logic push;
    logic pop;
    logic [47:0] head;
    s_nxt = s_r;
    mem_we = 1'b0;
    mem_addr = s_r.wptr;
    mem_wdata = s_r.hold;
    wr_rise = p.wr_n & ~s_r.wr_n_d;
    rd_fall = ~p.rd_n & s_r.rd_n_d;
    sclk_rise = p.sclk & ~s_r.sclk_d;
    cclk_rise = p.cclk & ~s_r.cclk_d;
    rd_en = s_r.cfg_filter[ffe_pkg::RD_EN_BIT];
    in_len = eff_len(s_r.in_fmt);
    mx_len = eff_len(s_r.mix_fmt);
    in_msb = s_r.in_fmt[ffe_pkg::IN_MSB_FIRST_BIT];
    mx_msb = s_r.mix_fmt[ffe_pkg::MIX_MSB_FIRST_BIT];
    push = 1'b0;
    pop = 1'b0;
    head = s_r.f0;
    s_nxt.wr_n_d = p.wr_n;
    s_nxt.rd_n_d = p.rd_n;
    s_nxt.sclk_d = p.sclk;
    s_nxt.cclk_d = p.cclk;
    s_nxt.out_wr = 1'b0;

    // configuration writes, taken when the strobe returns high
    if (wr_rise) begin
      if (p.addr == ffe_pkg::COEFF_PORT_ADDR) begin
        // no interlock with the filter: a load mid-run may corrupt outputs
        if (!rd_en && !s_r.wfull) begin
          s_nxt.hold[8*s_r.lane +: 8] = p.data;
          s_nxt.lane = s_r.lane + 2'h1;
          if (s_r.lane == ffe_pkg::LANE_LAST) begin
            mem_we = 1'b1;
            mem_wdata = {p.data, s_r.hold[23:0]};
            if (s_r.wptr == ffe_pkg::WPTR_LAST) s_nxt.wfull = 1'b1;
            else s_nxt.wptr = s_r.wptr + 7'h01;
          end
        end
      end else begin
        s_nxt.wptr = '0;
        s_nxt.lane = '0;
        s_nxt.wfull = 1'b0;
        s_nxt.rptr = '0;
        unique case (p.addr)
          ffe_pkg::CFG_FILTER_ADDR: s_nxt.cfg_filter = p.data;
          ffe_pkg::IN_FMT_ADDR: s_nxt.in_fmt = p.data;
          ffe_pkg::MIX_FMT_ADDR: s_nxt.mix_fmt = p.data;
          default: ;
        endcase
        if (p.addr == ffe_pkg::CFG_FILTER_ADDR && p.data[ffe_pkg::RD_EN_BIT])
          s_nxt.rptr = '0;
      end
    end

    // configuration reads, data launched on the falling strobe
    if (rd_fall) begin
      if (p.addr == ffe_pkg::COEFF_PORT_ADDR) begin
        if (rd_en) begin
          s_nxt.rdata = mem_rword[8*s_r.rptr[1:0] +: 8];
          s_nxt.rptr = s_r.rptr + 9'h001;
        end else begin
          s_nxt.rdata = '0;
        end
      end else begin
        s_nxt.wptr = '0;
        s_nxt.lane = '0;
        s_nxt.wfull = 1'b0;
        s_nxt.rptr = '0;
        unique case (p.addr)
          ffe_pkg::CFG_FILTER_ADDR: s_nxt.rdata = s_r.cfg_filter;
          ffe_pkg::IN_FMT_ADDR: s_nxt.rdata = s_r.in_fmt;
          ffe_pkg::MIX_FMT_ADDR: s_nxt.rdata = s_r.mix_fmt;
          default: s_nxt.rdata = '0;
        endcase
      end
    end

    // serial side, all on the sampled serial clock rise
    if (sclk_rise) begin
      if (p.smp_sync) begin
        s_nxt.in_hold = align(s_r.in_sr, in_len, in_msb,
                              s_r.in_fmt[ffe_pkg::FMT_OFFSET_BIT]);
        s_nxt.in_sr = '0;
        s_nxt.in_cnt = '0;
        if (!s_r.prod_v) begin
          s_nxt.m_a = s_nxt.in_hold;
          s_nxt.m_b = s_r.mx_hold;
          s_nxt.m_cnt = in_len;
          s_nxt.m_busy = 1'b1;
        end
      end else if (s_r.in_cnt < in_len) begin
        s_nxt.in_sr = shift_in(s_r.in_sr, p.din, in_msb);
        s_nxt.in_cnt = s_r.in_cnt + 5'h01;
      end

      if (s_r.mix_fmt[ffe_pkg::MIX_SERIAL_SEL_BIT]) begin
        if (p.mix_sync) begin
          s_nxt.mx_hold = align(s_r.mx_sr, mx_len, mx_msb, 1'b0);
          s_nxt.mx_sr = '0;
          s_nxt.mx_cnt = '0;
          // a serial factor pairs with the sample sent beside it, not the one before
          if (p.smp_sync && !s_r.prod_v) s_nxt.m_b = s_nxt.mx_hold;
        end else if (s_r.mx_cnt < mx_len) begin
          s_nxt.mx_sr = shift_in(s_r.mx_sr, p.mix_din, mx_msb);
          s_nxt.mx_cnt = s_r.mx_cnt + 5'h01;
        end
      end else if (p.smp_sync) begin
        s_nxt.mx_hold = s_r.tbl;
        s_nxt.tbl = tbl_decode(p.mix_sync, p.mix_din);
      end

      // sample bits walk through the multiplier, product appears after the last
      if (s_r.m_busy && !p.smp_sync) begin
        if (s_r.m_cnt == 5'h01) begin
          s_nxt.m_busy = 1'b0;
          s_nxt.prod = ffe_pkg::PROD_W'($signed(s_r.m_a) * $signed(s_r.m_b));
          s_nxt.prod_v = 1'b1;
        end
        s_nxt.m_cnt = s_r.m_cnt - 5'h01;
      end
    end

    // two-entry buffer; a full buffer holds the product and stalls new multiplies
    if (cclk_rise && regfile_ready_in && s_r.f_cnt != 2'h0) begin
      pop = 1'b1;
      s_nxt.out_data = head;
      s_nxt.out_wr = 1'b1;
    end
    if (s_r.prod_v && (s_r.f_cnt != ffe_pkg::FIFO_DEPTH || pop)) push = 1'b1;
    if (push) s_nxt.prod_v = 1'b0;
    unique case ({push, pop})
      2'b10: begin
        if (s_r.f_cnt == 2'h0) s_nxt.f0 = s_r.prod;
        else s_nxt.f1 = s_r.prod;
        s_nxt.f_cnt = s_r.f_cnt + 2'h1;
      end
      2'b01: begin
        s_nxt.f0 = s_r.f1;
        s_nxt.f_cnt = s_r.f_cnt - 2'h1;
      end
      2'b11: begin
        if (s_r.f_cnt == 2'h1) s_nxt.f0 = s_r.prod;
        else begin
          s_nxt.f0 = s_r.f1;
          s_nxt.f1 = s_r.prod;
        end
      end
      default: ;
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      s_r <= '0;
      s_r.wr_n_d <= 1'b1;
      s_r.rd_n_d <= 1'b1;
      // synchroniser resets high: match it so no false clock edge follows reset
      s_r.sclk_d <= 1'b1;
      s_r.cclk_d <= 1'b1;
      s_r.cfg_filter <= ffe_pkg::CFG_FILTER_RST;
      s_r.in_fmt <= ffe_pkg::IN_FMT_RST;
      s_r.mix_fmt <= ffe_pkg::MIX_FMT_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  // store has no reset: contents are undefined until loaded
  always_ff @(posedge clk_in) begin
    if (mem_we) begin
      coeff_mem[mem_addr] <= mem_wdata;
    end
  end

  assign config_byte_bus_out = s_r.rdata;
  assign config_byte_bus_oe_out = ~p.rd_n & ~s_r.rd_n_d;
  assign regfile_data_out = s_r.out_data;
  assign regfile_wr_out = s_r.out_wr;
endmodule // ffe_front_end

// *** testbench/ffe_front_end_assertions.sv ***
// checker: port-level timing of the filter front end
`timescale 1ns/10ps
module ffe_front_end_checker (
  // clock and reset
  input wire logic clk_in,
  input wire logic sys_rst_in,
  // configuration port
  input wire logic rd_n_in,
  input wire logic [7:0] config_byte_bus_out,
  input wire logic config_byte_bus_oe_out,
  // register file side
  input wire logic compute_clock_in,
  input wire logic regfile_ready_in,
  input wire logic [47:0] regfile_data_out,
  input wire logic regfile_wr_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);
  // synchroniser depth allows a few cycles of slack on the strobe
  chk_oe_on_read: assert property (!rd_n_in [*6] |-> config_byte_bus_oe_out)
    else $error("bus not driven during read");
  chk_oe_off_idle: assert property (rd_n_in [*6] |-> !config_byte_bus_oe_out)
    else $error("bus driven without read");
  chk_oe_cause: assert property ($rose(config_byte_bus_oe_out) |-> !$past(rd_n_in, 2))
    else $error("bus driven too early");
  chk_read_hold: assert property (config_byte_bus_oe_out && $past(config_byte_bus_oe_out)
    |-> $stable(config_byte_bus_out))
    else $error("read byte moved while driven");
  chk_wr_spacing: assert property (regfile_wr_out |=> !regfile_wr_out [*3])
    else $error("product written twice");
  chk_wr_ready: assert property (regfile_wr_out |-> $past(regfile_ready_in))
    else $error("product written while not ready");
  chk_wr_compute_clock: assert property (regfile_wr_out |-> $past(compute_clock_in, 2)
    || $past(compute_clock_in, 3) || $past(compute_clock_in, 4))
    else $error("product write without compute clock rise");
  chk_data_with_wr: assert property ($changed(regfile_data_out) |-> regfile_wr_out)
    else $error("product data moved without write");
endmodule // ffe_front_end_checker

bind ffe_front_end ffe_front_end_checker i_chk (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
  .rd_n_in(rd_n_in), .config_byte_bus_out(config_byte_bus_out),
  .config_byte_bus_oe_out(config_byte_bus_oe_out), .compute_clock_in(compute_clock_in),
  .regfile_ready_in(regfile_ready_in), .regfile_data_out(regfile_data_out),
  .regfile_wr_out(regfile_wr_out));

// *** testbench/ffe_serial_src.sv ***
// serial port model: sends sample and mix frames
`timescale 1ns/10ps
module ffe_serial_src (
  // clock
  input wire logic clk_in,
  // serial pins
  output logic sclk_out,
  output logic din_out,
  output logic sync_out,
  output logic mix_bit_out,
  output logic mxsync_out
);
  // mix pins idle high: table passthrough
  initial begin
    sclk_out = 1'b0;
    din_out = 1'b0;
    sync_out = 1'b0;
    mix_bit_out = 1'b1;
    mxsync_out = 1'b1;
  end
  // serial clock only runs inside a frame; unused bits toggle as junk
  task automatic frame(input logic [23:0] s, input int len, input bit msb,
                       input logic [23:0] m, input bit tbl, input logic [1:0] code);
    for (int i = -1; i < 24; i++) begin
      sync_out = (i < 0);
      din_out = (i < 0 || i >= len) ? ~din_out : (msb ? s[len-1-i] : s[i]);
      mxsync_out = tbl ? code[1] : (i < 0);
      mix_bit_out = tbl ? code[0] : (i < 0 ? ~mix_bit_out : m[23-i]);
      repeat (4) @(negedge clk_in);
      sclk_out = 1'b1;
      repeat (4) @(negedge clk_in);
      sclk_out = 1'b0;
    end
    din_out = ~din_out;
  endtask
endmodule // ffe_serial_src

// *** testbench/test_ffe_front_end.sv ***
// testbench: coefficient store, serial inputs and product hand-off
`timescale 1ns/10ps
module test_ffe_front_end;
  logic clk_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic [2:0] addr = 3'h0;
  logic [7:0] host_d = 8'h00;
  logic wr_n = 1'b1;
  logic rd_n = 1'b1;
  logic cclk = 1'b0;
  logic ready = 1'b1;
  logic [7:0] bus_out;
  logic bus_oe;
  logic sclk, din, sync, mix_bit, mxsync;
  logic [47:0] data;
  logic wr;
  logic [7:0] d;
  logic [47:0] got[$];
  int num_errors = 0;
  int total_checks = 0;

  always #12.5 clk_in = ~clk_in;
  // compute clock offset so its edges never meet the system clock
  initial begin
    #7;
    forever #50 cclk = ~cclk;
  end
  // sampled mid-cycle, away from the edge that launches the pulse
  always @(negedge clk_in) if (wr === 1'b1) got.push_back(data);

  ffe_front_end i_dut (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
    .config_address_lines_in(addr), .config_byte_bus_in(bus_oe ? bus_out : host_d),
    .config_byte_bus_out(bus_out), .config_byte_bus_oe_out(bus_oe), .wr_n_in(wr_n),
    .rd_n_in(rd_n), .serial_clock_in(sclk), .sample_serial_in(din),
    .sample_word_sync_in(sync), .mix_serial_in(mix_bit), .mix_word_sync_in(mxsync),
    .compute_clock_in(cclk), .regfile_ready_in(ready), .regfile_data_out(data),
    .regfile_wr_out(wr));
  ffe_serial_src i_src (.clk_in(clk_in), .sclk_out(sclk), .din_out(din),
    .sync_out(sync), .mix_bit_out(mix_bit), .mxsync_out(mxsync));

  task automatic chk(input logic [47:0] g, input logic [47:0] e);
    total_checks++;
    if (g !== e) begin
      num_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // address and data held well past the strobe rise
  task automatic cw(input logic [2:0] a, input logic [7:0] v);
    @(negedge clk_in);
    addr = a;
    host_d = v;
    wr_n = 1'b0;
    repeat (4) @(negedge clk_in);
    wr_n = 1'b1;
    repeat (4) @(negedge clk_in);
  endtask
  task automatic cr(input logic [2:0] a, output logic [7:0] v);
    @(negedge clk_in);
    addr = a;
    host_d = ~host_d;
    rd_n = 1'b0;
    repeat (6) @(negedge clk_in);
    v = bus_out;
    rd_n = 1'b1;
    repeat (4) @(negedge clk_in);
  endtask
  function automatic logic [7:0] pat(input int k);
    return 8'(k * 7 + (k >> 8));
  endfunction
  function automatic logic [47:0] mul(input logic [23:0] a, input logic [23:0] b);
    logic signed [47:0] x;
    logic signed [47:0] y;
    x = $signed(a);
    y = $signed(b);
    return x * y;
  endfunction
  function automatic logic [23:0] dec(input logic [1:0] c);
    return c == 2'h3 ? ffe_pkg::MIX_PLUS_ONE : (c == 2'h1 ? ffe_pkg::MIX_MINUS_ONE : 24'h0);
  endfunction
  task automatic wait_prod(input int n);
    for (int i = 0; i < 2000 && got.size() < n; i++) @(negedge clk_in);
    chk(48'(got.size()), 48'(n));
  endtask

  // 129 words written: the last must not land anywhere
  task automatic t_fill();
    cw(3'h1, 8'h00);
    cw(ffe_pkg::CFG_FILTER_ADDR, 8'h00);
    for (int k = 0; k < 516; k++) cw(3'h2, k < 512 ? pat(k) : 8'hEE);
    cw(ffe_pkg::CFG_FILTER_ADDR, 8'h10);
    for (int k = 0; k < 512; k++) begin
      cr(3'h2, d);
      chk(48'(d), 48'(pat(k)));
    end
  endtask
  task automatic t_ptr();
    cw(ffe_pkg::CFG_FILTER_ADDR, 8'h00);
    cr(3'h2, d);
    chk(48'(d), 48'h0);
    cw(3'h2, 8'h11);
    cw(3'h2, 8'h22);
    cr(ffe_pkg::IN_FMT_ADDR, d);
    chk(48'(d), 48'(ffe_pkg::IN_FMT_RST));
    for (int i = 0; i < 4; i++) cw(3'h2, 8'hA0 + 8'(i));
    cw(ffe_pkg::CFG_FILTER_ADDR, 8'h10);
    for (int i = 0; i < 4; i++) cw(3'h2, 8'h55);
    cr(ffe_pkg::CFG_FILTER_ADDR, d);
    chk(48'(d), 48'h10);
    for (int i = 0; i < 8; i++) begin
      cr(3'h2, d);
      chk(48'(d), 48'(i < 4 ? 8'hA0 + 8'(i) : pat(i)));
    end
  endtask
  // first two products come from the reset holding registers and are skipped
  task automatic t_table();
    logic [23:0] s [6] = '{24'h0, 24'h123456, 24'hFEDCBA, 24'h0F0F0F, 24'h7ABCDE, 24'h0};
    logic [1:0] c [6] = '{2'h3, 2'h1, 2'h0, 2'h2, 2'h3, 2'h3};
    got.delete();
    for (int i = 0; i < 6; i++) i_src.frame(s[i], 24, 1'b0, 24'h0, 1'b1, c[i]);
    wait_prod(6);
    for (int k = 1; k < 5; k++) chk(got[k+1], mul(s[k], dec(c[k-1])));
  endtask
  // two products wait in a full buffer while ready is low and must all arrive
  task automatic t_serial();
    logic [7:0] v [5] = '{8'h00, 8'hFF, 8'h81, 8'h40, 8'h3C};
    logic [23:0] m [5] = '{24'h400000, 24'hC00001, 24'h7FFFFF, 24'h123456, 24'h0};
    cw(ffe_pkg::IN_FMT_ADDR, 8'h68);
    cw(ffe_pkg::MIX_FMT_ADDR, 8'h78);
    got.delete();
    for (int i = 0; i < 5; i++) begin
      i_src.frame(24'(v[i]), 8, 1'b1, m[i], 1'b0, 2'h0);
      ready = (i >= 2);
      repeat (40) @(negedge clk_in);
    end
    wait_prod(5);
    for (int k = 0; k < 4; k++) chk(got[k+1], mul({v[k] ^ 8'h80, 16'h0}, m[k]));
  endtask

  task automatic tally_and_finish();
    $display("checks=%0d errors=%0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  initial begin
    repeat (12) @(negedge clk_in);
    sys_rst_in = 1'b0;
    repeat (4) @(negedge clk_in);
    t_fill();
    t_ptr();
    t_table();
    t_serial();
    tally_and_finish();
  end
  initial begin
    #2_000_000;
    num_errors++;
    tally_and_finish();
  end
endmodule // test_ffe_front_end
